// *** core/bmu_core.sv ***
// Two-wire bus master unit: APB register file, byte sequencer, pins.
// Assumes open-drain pins with external pull-ups and a bus-rate clock
// from a timer, both asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module bmu_core
    import bmu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bmu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);
    import bmu_pkg::*;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        reg_hit = (a == {2'b00, idx, 2'b00});
    endfunction

    // APB slave: one wait state, so every output stays registered
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    wire acc = psel & penable;
    wire hit_en = reg_hit(paddr, IDX_EN);
    wire hit_ctl = reg_hit(paddr, IDX_CTL);
    wire hit_dat = reg_hit(paddr, IDX_DAT);
    wire hit_ictl = reg_hit(paddr, IDX_ICTL);
    wire hit_any = hit_en | hit_ctl | hit_dat | hit_ictl;
    wire done = acc & pready_q;
    wire wr_en = done & pwrite & hit_en;
    wire wr_ctl = done & pwrite & hit_ctl;
    wire wr_dat = done & pwrite & hit_dat;
    wire wr_ictl = done & pwrite & hit_ictl;
    wire rd_dat = done & ~pwrite & hit_dat;

    // Software registers
    logic en_q, start_request_bit_q, stp_q, filt_q, tbsy_q, rbsy_q;
    logic rdy_q, rxe_q, txe_q, ack_q, tie_q, rie_q, tx_pend_q, irq_q;
    logic [7:0] data_q;

    logic [15:0] ctl_rd, dat_rd;
    assign ctl_rd = {6'h00, rbsy_q, tbsy_q, 3'h0, filt_q, 2'h0, stp_q, start_request_bit_q};
    assign dat_rd = {4'h0, rdy_q, rxe_q, txe_q, ack_q, data_q};

    assign rd_mux = hit_en ? {31'h0000_0000, en_q} :
        hit_ctl ? {16'h0000, ctl_rd} :
        hit_dat ? {16'h0000, dat_rd} :
        hit_ictl ? {30'h0000_0000, rie_q, tie_q} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~hit_any;
            prdata_q <= (acc & ~pready_q & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Pin and bus clock synchronisers; stage one feeds stage two only
    logic [2:0] s1_q, s2_q;
    logic bclk_d_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 3'b111;
            s2_q <= 3'b111;
            bclk_d_q <= 1'b1;
        end else begin
            s1_q <= {bus_clk_in, scl_in, sda_in};
            s2_q <= s1_q;
            bclk_d_q <= s2_q[2];
        end
    end
    // Both bus clock edges advance the sequencer
    wire tick = en_q & (s2_q[2] ^ bclk_d_q);

    // Optional filter: a level is taken only after stable samples
    logic [FILT_LEN-1:0] scl_h_q, sda_h_q;
    logic scl_f_q, sda_f_q;
    wire scl_stable = (&scl_h_q) | ~(|scl_h_q);
    wire sda_stable = (&sda_h_q) | ~(|sda_h_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_h_q <= '1;
            sda_h_q <= '1;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            scl_h_q <= {scl_h_q[FILT_LEN-2:0], s2_q[1]};
            sda_h_q <= {sda_h_q[FILT_LEN-2:0], s2_q[0]};
            if (!filt_q || scl_stable) begin
                scl_f_q <= filt_q ? scl_h_q[0] : s2_q[1];
            end
            if (!filt_q || sda_stable) begin
                sda_f_q <= filt_q ? sda_h_q[0] : s2_q[0];
            end
        end
    end

    // Byte sequencer
    bmu_state_t st_q, st_d;
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic tx_mode_q, bus_busy_q, scl_oe_q, sda_oe_q;
    logic scl_drv_d, sda_drv_d;
    logic load_tx, load_rx, bit_smp, byte_end, start_done, stop_done;
    wire last_bit = (cnt_q == LAST_BIT);
    // Count passes the ack slot only after its sample is taken
    wire bits_done = (cnt_q == LAST_BIT + 4'h1);
    wire tx_bit = last_bit ? 1'b0 : ~sh_q[7];
    wire rx_bit = last_bit ? ~ack_q : 1'b0;
    wire stop_ok = stp_q & ~txe_q & ~rxe_q & ~start_request_bit_q;

    always_comb begin
        st_d = st_q;
        scl_drv_d = scl_oe_q;
        sda_drv_d = sda_oe_q;
        load_tx = 1'b0;
        load_rx = 1'b0;
        bit_smp = 1'b0;
        byte_end = 1'b0;
        start_done = 1'b0;
        stop_done = 1'b0;
        if (tick) begin
            unique case (st_q)
                S_IDLE: if (start_request_bit_q) begin
                    sda_drv_d = 1'b1;
                    start_done = 1'b1;
                    st_d = S_STA;
                end
                S_STA: begin
                    scl_drv_d = 1'b1;
                    st_d = S_HOLD;
                end
                S_HOLD: begin
                    if (start_request_bit_q) begin
                        sda_drv_d = 1'b0;
                        st_d = S_RS1;
                    end else if (txe_q) begin
                        load_tx = 1'b1;
                        st_d = S_BDAT;
                    end else if (rxe_q) begin
                        load_rx = 1'b1;
                        st_d = S_BDAT;
                    end else if (stop_ok) begin
                        sda_drv_d = 1'b1;
                        st_d = S_SP1;
                    end
                end
                S_RS1: begin
                    scl_drv_d = 1'b0;
                    st_d = S_RS2;
                end
                S_RS2: if (scl_f_q) begin
                    sda_drv_d = 1'b1;
                    start_done = 1'b1;
                    st_d = S_STA;
                end
                S_BDAT: begin
                    sda_drv_d = tx_mode_q ? tx_bit : rx_bit;
                    st_d = S_BRISE;
                end
                S_BRISE: begin
                    scl_drv_d = 1'b0;
                    st_d = S_BHI;
                end
                S_BHI: if (scl_f_q) begin
                    bit_smp = 1'b1;
                    st_d = S_BFALL;
                end
                S_BFALL: begin
                    scl_drv_d = 1'b1;
                    byte_end = bits_done;
                    st_d = bits_done ? S_HOLD : S_BDAT;
                end
                S_SP1: begin
                    scl_drv_d = 1'b0;
                    st_d = S_SP2;
                end
                S_SP2: if (scl_f_q) begin
                    sda_drv_d = 1'b0;
                    stop_done = 1'b1;
                    st_d = S_IDLE;
                end
                default: st_d = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            bus_busy_q <= 1'b0;
            tbsy_q <= 1'b0;
            rbsy_q <= 1'b0;
        end else if (!en_q) begin
            st_q <= S_IDLE;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            bus_busy_q <= 1'b0;
            tbsy_q <= 1'b0;
            rbsy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            scl_oe_q <= scl_drv_d;
            sda_oe_q <= sda_drv_d;
            bus_busy_q <= start_done | (bus_busy_q & ~stop_done);
            tbsy_q <= load_tx | (tbsy_q & ~byte_end);
            rbsy_q <= load_rx | (rbsy_q & ~byte_end);
        end
    end

    // Shift register and bit counter; MSB leaves and enters first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= DATA_RST;
            cnt_q <= 4'h0;
            tx_mode_q <= 1'b0;
        end else if (!en_q) begin
            cnt_q <= 4'h0;
        end else if (load_tx | load_rx) begin
            sh_q <= data_q;
            cnt_q <= 4'h0;
            tx_mode_q <= load_tx;
        end else if (bit_smp) begin
            if (!last_bit) begin
                sh_q <= {sh_q[6:0], sda_f_q};
            end
            cnt_q <= cnt_q + 4'h1;
        end
    end

    wire rx_done = byte_end & ~tx_mode_q;
    wire rxe_clr = bit_smp & ~tx_mode_q & (cnt_q == BIT7_IDX);
    wire ack_smp = bit_smp & tx_mode_q & last_bit;

    // Control register, enable and interrupt control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            filt_q <= 1'b0;
            tie_q <= 1'b0;
            rie_q <= 1'b0;
        end else begin
            if (wr_en) begin
                en_q <= pwdata[EN_ON];
            end
            if (wr_ctl) begin
                filt_q <= pwdata[CTL_FILT];
            end
            if (wr_ictl) begin
                tie_q <= pwdata[ICTL_TIE];
                rie_q <= pwdata[ICTL_RIE];
            end
        end
    end

    // Requests and execute bits: software set wins over hardware clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_request_bit_q <= 1'b0;
            stp_q <= 1'b0;
            txe_q <= 1'b0;
            rxe_q <= 1'b0;
        end else begin
            start_request_bit_q <= (wr_ctl & pwdata[CTL_START_REQUEST_BIT]) | (start_request_bit_q & ~start_done);
            stp_q <= (wr_ctl & pwdata[CTL_STP]) | (stp_q & ~stop_done);
            txe_q <= (wr_dat & pwdata[DAT_TXE]) | (txe_q & ~load_tx);
            rxe_q <= (wr_dat & pwdata[DAT_RXE]) | (rxe_q & ~rxe_clr);
        end
    end

    // Data field, ack bit, receive ready and transmit cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= DATA_RST;
            ack_q <= 1'b0;
        end else begin
            if (wr_dat) begin
                data_q <= pwdata[7:0];
            end else if (rx_done) begin
                data_q <= sh_q;
            end
            if (wr_dat) begin
                ack_q <= pwdata[DAT_ACK];
            end else if (ack_smp) begin
                ack_q <= sda_f_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_q <= 1'b0;
            tx_pend_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            rdy_q <= rx_done | (rdy_q & ~rd_dat);
            tx_pend_q <= load_tx | (tx_pend_q & ~wr_dat);
            irq_q <= (tie_q & tx_pend_q) | (rie_q & rdy_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign irq = irq_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_bit_end;
        tick && (st_q == S_BFALL);
    endsequence

    AST_IRQ_TX: assert property (load_tx && tie_q && !wr_dat |=> ##1 irq_q)
        else $error("transmit cause did not raise irq");
    AST_IRQ_RX: assert property (rx_done && rie_q && !rd_dat |=> ##1 irq_q)
        else $error("receive cause did not raise irq");
    AST_IRQ_OFF: assert property (!(tie_q && tx_pend_q) && !(rie_q && rdy_q) |=> !irq_q)
        else $error("irq without enabled cause");
    AST_TXE_CLR: assert property (load_tx && !wr_dat |=> !txe_q && tbsy_q)
        else $error("execute bit not cleared on load");
    AST_NO_TX: assert property (!txe_q |-> !load_tx)
        else $error("transmission without execute bit");
    AST_TX_FIRST: assert property (tick && st_q == S_HOLD && !start_request_bit_q && txe_q |-> !load_rx)
        else $error("reception ahead of transmission");
    AST_RDY_SET: assert property (rx_done && !wr_dat |=> rdy_q && data_q == $past(sh_q))
        else $error("received byte not loaded");
    AST_RD_CLR: assert property (rd_dat && !rx_done |=> !rdy_q)
        else $error("read did not clear ready flag");
    AST_STOP_OK: assert property (stop_done |-> !txe_q && !rxe_q && !start_request_bit_q)
        else $error("stop with pending request");
    AST_NINE: assert property (seq_bit_end |-> byte_end == (cnt_q == LAST_BIT + 4'h1))
        else $error("byte did not end on ninth clock");
    AST_RSV: assert property (pready_q |-> prdata_q[31:REG_W] == 16'h0000)
        else $error("reserved bits read nonzero");
    AST_OFF: assert property (!en_q |=> st_q == S_IDLE && !scl_oe_q && !sda_oe_q)
        else $error("sequencer active while disabled");
    AST_BUSY: assert property (st_q == S_HOLD |-> bus_busy_q)
        else $error("bus not marked busy while held");
endmodule // bmu_core
`default_nettype wire

// *** core/bmu_pkg.sv ***
// Package for the two-wire bus master unit: register indices,
// field positions, reset values and the sequencer state type.
// Assumes a 32-bit APB bus; each 16-bit register takes one word.
package bmu_pkg;
    localparam int unsigned ADDR_W = 20;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_EN = 16'h4340;
    localparam logic [15:0] IDX_CTL = 16'h4342;
    localparam logic [15:0] IDX_DAT = 16'h4344;
    localparam logic [15:0] IDX_ICTL = 16'h4346;
    localparam int unsigned REG_W = 16;
    // master_enable
    localparam int unsigned EN_ON = 0;
    // master_control
    localparam int unsigned CTL_START_REQUEST_BIT = 0;
    localparam int unsigned CTL_STP = 1;
    localparam int unsigned CTL_FILT = 4;
    localparam int unsigned CTL_TBSY = 8;
    localparam int unsigned CTL_RBSY = 9;
    // master_data
    localparam int unsigned DAT_ACK = 8;
    localparam int unsigned DAT_TXE = 9;
    localparam int unsigned DAT_RXE = 10;
    localparam int unsigned DAT_RDY = 11;
    // master_irq_control
    localparam int unsigned ICTL_TIE = 0;
    localparam int unsigned ICTL_RIE = 1;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] LAST_BIT = 4'h8;
    localparam logic [3:0] BIT7_IDX = 4'h0;
    localparam int unsigned FILT_LEN = 3;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_STA = 4'h1,
        S_HOLD = 4'h2,
        S_RS1 = 4'h3,
        S_RS2 = 4'h4,
        S_RS3 = 4'h5,
        S_BDAT = 4'h6,
        S_BRISE = 4'h7,
        S_BHI = 4'h8,
        S_BFALL = 4'h9,
        S_SP1 = 4'ha,
        S_SP2 = 4'hb,
        S_SP3 = 4'hc
    } bmu_state_t;
endpackage

// *** bench/bmu_slave_model.sv ***
// Behavioural slave for the two-wire bus: acks writes, sends tx_byte on reads.
// Assumes open-drain lines resolved with pull-ups by the bench.
`timescale 1ns/1ps
`default_nettype none
module bmu_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic nak_all,
    input wire logic stretch,
    input wire logic [7:0] tx_byte,
    output logic scl_pull,
    output logic sda_pull,
    output logic [7:0] last_rx,
    output logic mack
);
    int bitn;
    logic [7:0] sh;
    logic on, addr_ph, rd_ph, quit;
    initial begin
        scl_pull = 0;
        sda_pull = 0;
        on = 0;
        bitn = -1;
        last_rx = 8'h00;
        mack = 1'b0;
    end
    // Start or repeated start; any address is answered, a known limitation
    always @(negedge sda) if (scl) begin
        on = 1;
        addr_ph = 1;
        rd_ph = 0;
        quit = 0;
        bitn = -1;
    end
    always @(posedge sda) if (scl) begin
        on = 0;
        sda_pull = 0;
    end
    always @(posedge scl) if (on) begin
        if (bitn < 8)
            sh = {sh[6:0], sda};  // MSB first
        else if (rd_ph) begin
            mack = sda;  // Response driven by the master
            quit = sda;
        end
    end
    always @(negedge scl) if (on) begin
        bitn = (bitn == 8) ? 0 : bitn + 1;
        if (bitn == 8) begin
            if (!rd_ph)
                last_rx = sh;
            sda_pull = !rd_ph && !nak_all;  // Ninth clock is the ack slot
            if (addr_ph)
                rd_ph = sh[0];
            addr_ph = 0;
        end else
            sda_pull = rd_ph && !quit && !tx_byte[7 - bitn];
    end
    // Slow slave: holds SCL low a while after each fall
    always @(negedge scl) if (on && stretch) begin
        scl_pull = 1;
        #150;
        scl_pull = 0;
    end
endmodule // bmu_slave_model
`default_nettype wire

// *** bench/bmu_core_tb.sv ***
// Self-checking bench for bmu_core: registers over APB, bus transfers, irq.
// Assumes the slave model on open-drain lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module bmu_core_tb;
    import bmu_pkg::*;
    typedef struct {
        logic [ADDR_W-1:0] a;
        logic [31:0] wd;
        logic [31:0] exp;
        logic err;
    } bmu_row_t;
    localparam logic [ADDR_W-1:0] A_EN = ADDR_W'({IDX_EN, 2'b00});
    localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'({IDX_CTL, 2'b00});
    localparam logic [ADDR_W-1:0] A_DAT = ADDR_W'({IDX_DAT, 2'b00});
    localparam logic [ADDR_W-1:0] A_ICTL = ADDR_W'({IDX_ICTL, 2'b00});
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bus_clk_in = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, d;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, e;
    logic scl_pull, sda_pull, mack, nak_all = 0, stretch = 0;
    logic [7:0] tx_byte = 8'h96, last_rx;
    logic scl_line, sda_line;
    int failures = 0, tests_run = 0;
    bmu_row_t rows[8];
    logic [ADDR_W-1:0] regs[4] = '{A_EN, A_CTL, A_DAT, A_ICTL};
    assign scl_line = (scl_oe ? scl_o : 1'b1) & ~scl_pull;
    assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
    always #2.5 pclk = ~pclk;
    initial begin
        #13.3;
        forever #40 bus_clk_in = ~bus_clk_in;  // Well under pclk/6
    end
    bmu_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_clk_in(bus_clk_in), .scl_in(scl_line), .sda_in(sda_line),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    bmu_slave_model u_slave (.scl(scl_line), .sda(sda_line), .nak_all(nak_all),
        .stretch(stretch), .tx_byte(tx_byte), .scl_pull(scl_pull), .sda_pull(sda_pull),
        .last_rx(last_rx), .mack(mack));
    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Request held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic poll(input logic [ADDR_W-1:0] a, input int b, input logic v);
        logic [31:0] r;
        logic x;
        int n = 0;
        do begin
            apb(1'b0, a, 32'h0, r, x);
            n++;
        end while (r[b] !== v && n < 400);
        if (r[b] !== v) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic wait_irq(input logic v);
        int n = 0;
        while (irq !== v && n < 40) begin
            @(posedge pclk);
            n++;
        end
        check("irq", 32'(v), 32'(irq));
    endtask
    task automatic xfer(input logic [31:0] w, input int exe, input int busy);
        logic [31:0] r;
        logic x;
        apb(1'b1, A_DAT, w, r, x);
        poll(A_DAT, exe, 1'b0);
        poll(A_CTL, busy, 1'b0);
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        tally_and_finish();
    end
    initial begin
        // Reserved bits always written as zero
        rows[0] = '{A_ICTL, 32'h3, 32'h3, 1'b0};
        rows[1] = '{A_ICTL, 32'h0, 32'h0, 1'b0};
        rows[2] = '{A_EN, 32'h1, 32'h1, 1'b0};
        rows[3] = '{A_CTL, 32'h10, 32'h10, 1'b0};
        rows[4] = '{A_CTL, 32'h0, 32'h0, 1'b0};
        rows[5] = '{A_DAT, 32'ha5, 32'ha5, 1'b0};
        rows[6] = '{A_DAT, 32'h1ff, 32'h1ff, 1'b0};
        rows[7] = '{20'h10d04, 32'h1, 32'h0, 1'b1};
        repeat (5) @(posedge pclk);
        presetn <= 1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].wd, d, e);
            check("wr_err", 32'(rows[i].err), 32'(e));
            apb(1'b0, rows[i].a, 32'h0, d, e);
            check("rd_err", 32'(rows[i].err), 32'(e));
            check("rd_val", rows[i].exp, d);
        end
        check("irq_off", 32'h0, 32'(irq));
        apb(1'b1, A_ICTL, 32'h1, d, e);
        apb(1'b1, A_CTL, 32'h1, d, e);
        poll(A_CTL, CTL_START_REQUEST_BIT, 1'b0);
        repeat (40) @(posedge pclk);
        check("held", 32'h3, 32'({scl_oe, sda_oe}));
        check("pin_lvl", 32'h0, 32'({scl_o, sda_o}));
        apb(1'b1, A_DAT, 32'h54, d, e);
        repeat (200) @(posedge pclk);
        apb(1'b0, A_CTL, 32'h0, d, e);
        check("no_tx", 32'h0, 32'(d[CTL_TBSY]));
        check("no_irq", 32'h0, 32'(irq));
        apb(1'b1, A_DAT, 32'h254, d, e);
        poll(A_DAT, DAT_TXE, 1'b0);
        wait_irq(1'b1);
        apb(1'b0, A_CTL, 32'h0, d, e);
        check("tx_active_flag", 32'h1, 32'(d[CTL_TBSY]));
        apb(1'b1, A_DAT, 32'h2c3, d, e);
        wait_irq(1'b0);
        poll(A_DAT, DAT_TXE, 1'b0);
        poll(A_CTL, CTL_TBSY, 1'b0);
        check("tx_byte", 32'hc3, 32'(last_rx));
        apb(1'b0, A_DAT, 32'h0, d, e);
        check("ack", 32'h0, 32'(d[DAT_ACK]));
        nak_all <= 1;
        xfer(32'h211, DAT_TXE, CTL_TBSY);
        apb(1'b0, A_DAT, 32'h0, d, e);
        check("nak", 32'h1, 32'(d[DAT_ACK]));
        nak_all <= 0;
        stretch <= 1;
        apb(1'b1, A_ICTL, 32'h2, d, e);
        wait_irq(1'b0);
        apb(1'b1, A_CTL, 32'h11, d, e);
        poll(A_CTL, CTL_START_REQUEST_BIT, 1'b0);
        apb(1'b1, A_DAT, 32'h655, d, e);
        poll(A_DAT, DAT_TXE, 1'b0);
        poll(A_DAT, DAT_RXE, 1'b0);
        apb(1'b0, A_CTL, 32'h0, d, e);
        check("rx_active_flag", 32'h1, 32'(d[CTL_RBSY]));
        poll(A_CTL, CTL_RBSY, 1'b0);
        check("addr_first", 32'h55, 32'(last_rx));
        check("ack_sent", 32'h0, 32'(mack));
        wait_irq(1'b1);
        apb(1'b0, A_DAT, 32'h0, d, e);
        check("rx_data", 32'h896, d);
        wait_irq(1'b0);
        apb(1'b0, A_DAT, 32'h0, d, e);
        check("rdy_clr", 32'h0, 32'(d[DAT_RDY]));
        tx_byte <= 8'h3c;
        xfer(32'h400, DAT_RXE, CTL_RBSY);
        tx_byte <= 8'h5a;
        xfer(32'h500, DAT_RXE, CTL_RBSY);
        check("nak_sent", 32'h1, 32'(mack));
        apb(1'b0, A_DAT, 32'h0, d, e);
        check("newest", 32'h95a, d);
        apb(1'b1, A_CTL, 32'h12, d, e);
        poll(A_CTL, CTL_STP, 1'b0);
        repeat (40) @(posedge pclk);
        check("bus_free", 32'h3, 32'({scl_line, sda_line}));
        check("released", 32'h0, 32'({scl_oe, sda_oe}));
        apb(1'b1, A_EN, 32'h0, d, e);
        apb(1'b1, A_CTL, 32'h1, d, e);
        repeat (100) @(posedge pclk);
        check("off_idle", 32'h0, 32'({scl_oe, sda_oe}));
        presetn <= 0;
        repeat (3) @(posedge pclk);
        check("rst_out", 32'h0, 32'({irq, scl_oe, sda_oe, pready, pslverr}));
        presetn <= 1;
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0, d, e);
            check("rst_val", 32'h0, d);
        end
        tally_and_finish();
    end
endmodule // bmu_core_tb
`default_nettype wire
